/* File: pir_consts.svh */
// Constants for the port intrusion response block
`ifndef PIR_CONSTS_SVH
`define PIR_CONSTS_SVH
// Partition reaction encodings
`define PIR_REACT_DIS 2'h0
`define PIR_REACT_ENA 2'h1
`define PIR_REACT_FOREVER 2'h2
// Reaction code that no setting uses; writes of it are ignored
`define PIR_REACT_BAD 2'h3
// Partition duration reset value, in seconds
`define PIR_TIME_RST 17'h00001
// Duration value that means unlimited
`define PIR_TIME_UNLIM 17'h00000
// Largest duration that a write may set, in seconds
`define PIR_TIME_MAX 17'h10000
// Count left when the next tick ends a partition
`define PIR_TIME_LAST 17'h00001
// Seconds taken off the countdown per tick
`define PIR_TIME_STEP 17'h00001
// Countdown reset value
`define PIR_CNT_RST 17'h00000
// Intruder address reset value
`define PIR_ADDR_RST 48'h000000000000
// Default port count and address width
`define PIR_NPORTS 8
`define PIR_ADDR_W 48
`endif

/* File: pir_pkg.sv */
// Types for the port intrusion response block
package pir_pkg;
    // Partition reaction setting
    typedef enum logic [1:0]
    {
        PIR_DIS = 2'b00,
        PIR_ENA = 2'b01,
        PIR_FOREVER = 2'b10
    } pir_react_e;
    // Frame summary from the forwarding path
    typedef struct packed
    {
        logic valid;
        logic [2:0] port;
        logic [47:0] src;
        logic [47:0] dst;
    } pir_frame_s;
endpackage

/* File: pir_port_intrusion.sv */
// Per-port intrusion response: source check, partition timers, destination filter
`timescale 1ns/100ps
`include "pir_consts.svh"
module pir_port_intrusion #(
    parameter int NPORTS = `PIR_NPORTS
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sec_tick,
    input wire pir_pkg::pir_frame_s i_frame,
    input wire logic [NPORTS-1:0] i_secure_ports,
    input wire logic [NPORTS-1:0] i_allowed,
    input wire logic i_check_en,
    input wire logic i_react_wr,
    input wire logic [1:0] i_react,
    input wire logic i_time_wr,
    input wire logic [16:0] i_time,
    input wire logic i_dafilt_wr,
    input wire logic i_dafilt,
    output logic o_intrusion,
    output logic [NPORTS-1:0] o_port_down,
    output logic o_drop,
    output logic [1:0] o_react,
    output logic [16:0] o_time
);
    //--------------------------------------------------
    // Settings and captured intrusion state
    //--------------------------------------------------
    pir_pkg::pir_react_e react_q; // Partition reaction
    logic [16:0] time_q; // Duration in seconds, 17 bits to reach 65536
    logic dafilt_q; // Destination filtering enable
    logic [47:0] intruder_q; // Last intruding address
    logic intruder_vld_q; // Intruder address captured
    logic intr_q; // Registered intrusion pulse

    //--------------------------------------------------
    // Event detection and destination match
    //--------------------------------------------------
    // Mismatch on a secured port raises the event
    wire port_secure = i_secure_ports[i_frame.port];
    wire intr_now = i_frame.valid && i_check_en && port_secure
                    && !i_allowed[i_frame.port];
    // Destination match against the captured intruder
    wire da_hit = dafilt_q && intruder_vld_q && (i_frame.dst == intruder_q);

    // Settings registers, write strobes from management
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            react_q <= pir_pkg::PIR_DIS;
            time_q <= `PIR_TIME_RST;
            dafilt_q <= 1'b0;
        end
        else
        begin
            // Unused code is dropped so the enum never holds it
            if (i_react_wr && i_react != `PIR_REACT_BAD)
                react_q <= pir_pkg::pir_react_e'(i_react);
            // Out-of-range durations are ignored, old value kept
            if (i_time_wr && i_time <= `PIR_TIME_MAX)
                time_q <= i_time;
            if (i_dafilt_wr)
                dafilt_q <= i_dafilt;
        end
    end

    // Intruder capture and event pulse
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            intruder_q <= `PIR_ADDR_RST;
            intruder_vld_q <= 1'b0;
            intr_q <= 1'b0;
            o_drop <= 1'b0;
        end
        else
        begin
            intr_q <= intr_now;
            // Frame to the intruder is dropped one cycle later
            o_drop <= i_frame.valid && da_hit;
            if (intr_now)
            begin
                intruder_q <= i_frame.src;
                intruder_vld_q <= 1'b1;
            end
        end
    end

    assign o_intrusion = intr_q;
    assign o_react = react_q;
    assign o_time = time_q;

    //--------------------------------------------------
    // Per-port partition state
    //--------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp++)
        begin : g_port
            logic down_q; // Port out of service
            logic timed_q; // Countdown armed
            logic [16:0] cnt_q; // Seconds left
            // Event addressed to this port
            wire hit = intr_now && (i_frame.port == 3'(gp));
            // Event wins over expiry in the same cycle unless the reaction is disabled
            always_ff @(posedge i_ref_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    down_q <= 1'b0;
                    timed_q <= 1'b0;
                    cnt_q <= `PIR_CNT_RST;
                end
                else if (hit && react_q != pir_pkg::PIR_DIS)
                begin
                    down_q <= 1'b1;
                    // Forever or zero duration never arms the timer
                    timed_q <= (react_q == pir_pkg::PIR_ENA)
                               && (time_q != `PIR_TIME_UNLIM);
                    cnt_q <= time_q;
                end
                else if (timed_q && i_sec_tick)
                begin
                    cnt_q <= cnt_q - `PIR_TIME_STEP;
                    // Last second used up: back in service
                    if (cnt_q == `PIR_TIME_LAST)
                    begin
                        down_q <= 1'b0;
                        timed_q <= 1'b0;
                    end
                end
            end
            assign o_port_down[gp] = down_q;

            // Unarmed partitions never come back
            perm_down_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
                (down_q && !timed_q && !hit) |=> down_q)
                else $error("permanent partition released");
            // Armed count reaching one releases on the tick
            expire_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
                (timed_q && i_sec_tick && cnt_q == `PIR_TIME_LAST && !hit) |=> !down_q)
                else $error("partition not released at expiry");
            // Each tick takes one second off an armed count
            tick_dec_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
                (timed_q && i_sec_tick && !hit) |=> cnt_q == $past(cnt_q) - `PIR_TIME_STEP)
                else $error("countdown did not step on tick");
            // Zero duration partitions without arming the timer
            zero_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
                (hit && react_q == pir_pkg::PIR_ENA && time_q == `PIR_TIME_UNLIM)
                |=> (down_q && !timed_q))
                else $error("zero duration armed a release");
            // Forever reaction never arms the timer
            forever_arm_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
                (hit && react_q == pir_pkg::PIR_FOREVER) |=> (down_q && !timed_q))
                else $error("forever reaction armed a release");
            // Disabled reaction leaves this port as it was
            dis_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
                (hit && react_q == pir_pkg::PIR_DIS && !(timed_q && i_sec_tick))
                |=> $stable(down_q))
                else $error("port state changed under disabled reaction");
            // Enabled reaction with a duration arms the timer
            arm_ena_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
                (hit && react_q == pir_pkg::PIR_ENA && time_q != `PIR_TIME_UNLIM)
                |=> (down_q && timed_q && cnt_q == $past(time_q)))
                else $error("enabled reaction did not arm the timer");
        end
    endgenerate

    //--------------------------------------------------
    // Block-level checks
    //--------------------------------------------------
    // Disabled reaction never partitions
    no_part_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (intr_now && react_q == pir_pkg::PIR_DIS && o_port_down == '0)
        |=> o_port_down == '0)
        else $error("port partitioned while reaction disabled");
    // Enabled reaction partitions the port next cycle
    part_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (intr_now && react_q != pir_pkg::PIR_DIS) |=> o_port_down[$past(i_frame.port)])
        else $error("port not partitioned on intrusion");
    // Intrusion pulse follows detection by one cycle
    intr_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        intr_now |=> o_intrusion)
        else $error("intrusion event not reported");
    // Filtered frames are dropped
    da_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_frame.valid && da_hit) |=> o_drop)
        else $error("frame to intruder not dropped");
    // Reaction never holds the unused code
    react_code_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_react != `PIR_REACT_BAD)
        else $error("reaction holds illegal code");
    // Duration stays within range
    time_rng_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_time <= `PIR_TIME_MAX)
        else $error("duration out of range");
    // No event, no intrusion pulse
    intr_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !intr_now |=> !o_intrusion)
        else $error("intrusion reported without an event");
    // Filtering off never drops a frame
    drop_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !dafilt_q |=> !o_drop)
        else $error("frame dropped while filtering off");
    // Writes of the unused code leave the reaction alone
    react_ign_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_react_wr && i_react == `PIR_REACT_BAD) |=> $stable(o_react))
        else $error("unused reaction code was taken");
    // Out-of-range duration writes are ignored
    time_ign_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_time_wr && i_time > `PIR_TIME_MAX) |=> $stable(o_time))
        else $error("out-of-range duration was taken");
    // Valid duration writes land on the next edge
    time_wr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_time_wr && i_time <= `PIR_TIME_MAX) |=> o_time == $past(i_time))
        else $error("duration write lost");
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the port intrusion response block
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    pir_pkg::pir_frame_s fr = '0;
    logic [7:0] sec = 8'hFF;
    logic [7:0] alw = 8'h00;
    logic chk = 1'b1;
    logic rwr = 1'b0;
    logic [1:0] rv = 2'h0;
    logic twr = 1'b0;
    logic [16:0] tv = 17'h00000;
    logic dwr = 1'b0;
    logic dv = 1'b0;
    logic intr;
    logic drop;
    logic [7:0] down;
    logic [1:0] react;
    logic [16:0] tme;
    logic mark = 1'b0;
    logic seen = 1'b0;
    // Expected state, kept from the settings written so far
    logic [7:0] xd = 8'h00;
    logic [1:0] xr = 2'h0;
    logic [16:0] xt = 17'h00001;
    logic [28:0] notes[$];
    logic [28:0] got;
    logic [47:0] s;
    int p;
    int q;
    int err_total = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    pir_port_intrusion #(.NPORTS(8)) dut_u (.i_ref_clk(clk), .i_rst(rst), .i_sec_tick(tick),
        .i_frame(fr), .i_secure_ports(sec), .i_allowed(alw), .i_check_en(chk),
        .i_react_wr(rwr), .i_react(rv), .i_time_wr(twr), .i_time(tv), .i_dafilt_wr(dwr),
        .i_dafilt(dv), .o_intrusion(intr), .o_port_down(down), .o_drop(drop),
        .o_react(react), .o_time(tme));
    // ------------------------------------------------------------
    // Driver: note the result due one edge later, strobes last one cycle
    // ------------------------------------------------------------
    task automatic step(input logic ei, input logic ed);
        notes.push_back({ei, ed, xd, xr, xt});
        mark = 1'b1;
        @(posedge clk);
        #1;
        mark = 1'b0;
        fr.valid = 1'b0;
        tick = 1'b0;
        rwr = 1'b0;
        twr = 1'b0;
        dwr = 1'b0;
    endtask
    task automatic send(input int pt, input logic ok, input logic [47:0] d, input logic ei,
        input logic ed, input logic part);
        fr = '{1'b1, pt[2:0], s, d};
        alw = ok ? 8'hFF : 8'h00;
        if (part)
            xd[pt] = 1'b1;
        step(ei, ed);
    endtask
    task automatic ticks(input int n);
        repeat (n)
        begin
            tick = 1'b1;
            step(1'b0, 1'b0);
        end
    endtask
    task automatic wr(input logic [1:0] r, input logic [16:0] t, input logic ir, input logic it);
        {rv, tv, rwr, twr} = {r, t, ir, it};
        step(1'b0, 1'b0);
    endtask
    // ------------------------------------------------------------
    // Monitor: oldest note against outputs one edge after its request
    // ------------------------------------------------------------
    always @(negedge clk)
    begin
        if (seen)
        begin
            got = notes.pop_front();
            samples_checked++;
            if ({intr, drop, down, react, tme} !== got)
            begin
                err_total++;
                $display("BAD %0t got %h want %h", $time, {intr, drop, down, react, tme}, got);
            end
        end
        seen = mark;
    end
    task automatic finish_test();
        $display("err_total=%0d samples_checked=%0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog: the sequence needs well under 2 us
    initial
    begin
        #20000;
        err_total++;
        finish_test();
    end
    initial
    begin
        void'($urandom(32'h5C755A2D));
        p = $urandom_range(7);
        q = (p + 1) % 8;
        s = {16'($urandom), $urandom};
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        step(1'b0, 1'b0);
        send(p, 1'b0, ~s, 1'b1, 1'b0, 1'b0);
        sec = 8'h00;
        send(p, 1'b0, ~s, 1'b0, 1'b0, 1'b0);
        sec = 8'hFF;
        send(p, 1'b1, ~s, 1'b0, 1'b0, 1'b0);
        chk = 1'b0;
        send(p, 1'b0, ~s, 1'b0, 1'b0, 1'b0);
        chk = 1'b1;
        wr(2'h3, 17'h00000, 1'b1, 1'b0);
        xr = 2'h1;
        wr(2'h1, 17'h00000, 1'b1, 1'b0);
        xt = 17'h00002;
        wr(2'h0, 17'h00002, 1'b0, 1'b1);
        send(p, 1'b0, ~s, 1'b1, 1'b0, 1'b1);
        ticks(1);
        xd[p] = 1'b0;
        ticks(1);
        xt = 17'h00000;
        wr(2'h0, 17'h00000, 1'b0, 1'b1);
        send(p, 1'b0, ~s, 1'b1, 1'b0, 1'b1);
        ticks(3);
        {xr, xt} = {2'h2, 17'h00001};
        wr(2'h2, 17'h00001, 1'b1, 1'b1);
        s = {16'($urandom), $urandom};
        send(q, 1'b0, ~s, 1'b1, 1'b0, 1'b1);
        ticks(2);
        wr(2'h0, 17'h10001, 1'b0, 1'b1);
        xt = 17'h10000;
        wr(2'h0, 17'h10000, 1'b0, 1'b1);
        {dv, dwr, sec} = {1'b1, 1'b1, 8'h00};
        step(1'b0, 1'b0);
        send(q, 1'b1, s, 1'b0, 1'b1, 1'b0);
        send(q, 1'b1, ~s, 1'b0, 1'b0, 1'b0);
        step(1'b0, 1'b0);
        @(posedge clk);
        #1;
        finish_test();
    end
endmodule
